//--- inc/rx_ring_pkg.sv
// Purpose: shared constants for the receive interrupt and status block
// Assumes: 16-bit register port, word addressed by index
// Notes: offsets and bit positions used by the main file
package rx_ring_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register indices
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h1;
  localparam logic [3:0] REG_DESC_STATUS = 4'h2;
  localparam logic [3:0] REG_BYTE_COUNT = 4'h3;
  localparam logic [3:0] REG_OWNER = 4'h4;
  // main status register positions
  localparam int ST_INIT_DONE = 8;
  localparam int ST_RX_INT = 10;
  localparam int ST_INT_EN = 6;
  localparam int ST_ERR_SUM = 15;
  localparam int ST_MISS = 12;
  localparam int ST_BABBLE = 14;
  // descriptor status word positions
  localparam int DS_ERR = 14;
  localparam int DS_FRAM = 13;
  localparam int DS_OFLO = 12;
  localparam int DS_CRC = 11;
  localparam int DS_BUFF = 10;
  localparam int DS_SOP = 9;
  localparam int DS_EOP = 8;
  // config register positions, then loopback length, CRC, init count and zero constants
  localparam int CF_LOOP = 0;
  localparam int CF_TXCRC = 1;
  localparam int CF_INIT = 2;
  localparam logic [15:0] LOOP_MAX_BYTES = 16'h0024;
  localparam logic [15:0] CRC_BYTES = 16'h0004;
  localparam int INIT_CYCLES = 16;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage

//--- logic/rx_desc_mem.sv
// Purpose: small descriptor status store, registered read
// Assumes: single clock, one write and one read port
// Notes: read data valid the cycle after the address
`timescale 1ns/1ps
module rx_desc_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem_ff [DEPTH];
  logic [DW-1:0] rd_data_ff;
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    rd_data_ff <= mem_ff[rd_addr_i];
  end
  assign rd_data_o = rd_data_ff;
endmodule

//--- logic/rx_ring_service.sv
// Purpose: receive completion, init-done and interrupt status for the controller
// Assumes: frame status arrives from the receive engine as one-cycle pulses
// Notes: descriptor words kept in a ring store; software reads back only the last descriptor status word
// Operation
// - hand-off of filled descriptor sets receive flag
// - status word holds summary and individual errors
// - loopback: no chaining, at most 36 bytes
// - multi-buffer: first start only, last end
// - init completion sets init-complete flag
// - write one clears flags; zero clears enable
// - error summary clears with all errors
// - interrupt is or of receive, init-complete and error summary flags, gated by enable
`timescale 1ns/1ps
module rx_ring_service #(
  parameter int RING_DEPTH = 8,
  parameter int RING_AW = 3,
  parameter int BUF_BYTES = 256
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic seg_valid_i,
  input wire logic [15:0] seg_bytes_i,
  input wire logic seg_last_i,
  input wire logic seg_fram_err_i,
  input wire logic seg_crc_err_i,
  input wire logic seg_oflo_err_i,
  input wire logic miss_err_i,
  input wire logic babble_err_i,
  input wire logic host_return_i,
  output logic seg_ready_o,
  output logic loop_len_err_o,
  output logic int_o
);
  typedef enum logic [1:0] {
    INIT_IDLE = 2'b00,
    INIT_RUN = 2'b01,
    INIT_DONE = 2'b10
  } init_state_type;

  init_state_type init_ff, nxt_init;
  logic [4:0] init_cnt_ff, nxt_init_cnt;
  logic rx_int_ff, nxt_rx_int;
  logic init_flag_ff, nxt_init_flag;
  logic int_en_ff, nxt_int_en;
  logic miss_ff, nxt_miss;
  logic babble_ff, nxt_babble;
  logic loop_ff, nxt_loop;
  logic txcrc_ff, nxt_txcrc;
  logic [15:0] exp_len_ff, nxt_exp_len;
  logic in_pkt_ff, nxt_in_pkt;
  logic [15:0] pkt_bytes_ff, nxt_pkt_bytes;
  logic [RING_AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [RING_AW:0] owned_ff, nxt_owned;
  logic loop_err_ff, nxt_loop_err;
  logic [15:0] last_status_ff, nxt_last_status;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [15:0] mem_rdata;
  logic mem_we;
  logic [15:0] desc_word;
  logic wr_status, wr_config;
  logic ring_full, err_sum;
  logic [15:0] expected;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  assign wr_status = wr_i && hit(addr_i, rx_ring_pkg::REG_STATUS);
  assign wr_config = wr_i && hit(addr_i, rx_ring_pkg::REG_CONFIG);
  assign ring_full = (owned_ff == (RING_AW+1)'(RING_DEPTH));
  assign seg_ready_o = !ring_full;
  assign err_sum = miss_ff | babble_ff;
  assign expected = txcrc_ff ? 16'(exp_len_ff + rx_ring_pkg::CRC_BYTES) : exp_len_ff;
  assign mem_we = seg_valid_i && !ring_full;

  always_comb begin
    desc_word = rx_ring_pkg::ZERO16;
    desc_word[rx_ring_pkg::DS_FRAM] = seg_fram_err_i;
    desc_word[rx_ring_pkg::DS_CRC] = seg_crc_err_i;
    desc_word[rx_ring_pkg::DS_OFLO] = seg_oflo_err_i;
    desc_word[rx_ring_pkg::DS_BUFF] = !seg_last_i
                                      && (loop_ff || (seg_bytes_i == rx_ring_pkg::ZERO16));
    desc_word[rx_ring_pkg::DS_ERR] = seg_fram_err_i | seg_crc_err_i | seg_oflo_err_i
                                     | desc_word[rx_ring_pkg::DS_BUFF];
    desc_word[rx_ring_pkg::DS_SOP] = !in_pkt_ff;
    desc_word[rx_ring_pkg::DS_EOP] = seg_last_i;
  end

  rx_desc_mem #(
    .DEPTH(RING_DEPTH),
    .AW(RING_AW),
    .DW(16)
  ) u_mem (
    .clk_i(clk_i),
    .wr_en_i(mem_we),
    .wr_addr_i(wr_ptr_ff),
    .wr_data_i(desc_word),
    .rd_addr_i(wdata_i[RING_AW-1:0]),
    .rd_data_o(mem_rdata)
  );

  always_comb begin
    nxt_init = init_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_init_flag = init_flag_ff;
    nxt_rx_int = rx_int_ff;
    nxt_int_en = int_en_ff;
    nxt_miss = miss_ff;
    nxt_babble = babble_ff;
    nxt_loop = loop_ff;
    nxt_txcrc = txcrc_ff;
    nxt_exp_len = exp_len_ff;
    nxt_in_pkt = in_pkt_ff;
    nxt_pkt_bytes = pkt_bytes_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_owned = owned_ff;
    nxt_loop_err = loop_err_ff;
    nxt_last_status = last_status_ff;
    // write-one clears; hardware set below wins
    if (wr_status) begin
      if (wdata_i[rx_ring_pkg::ST_RX_INT]) nxt_rx_int = 1'b0;
      if (wdata_i[rx_ring_pkg::ST_INIT_DONE]) nxt_init_flag = 1'b0;
      if (wdata_i[rx_ring_pkg::ST_MISS]) nxt_miss = 1'b0;
      if (wdata_i[rx_ring_pkg::ST_BABBLE]) nxt_babble = 1'b0;
      nxt_int_en = wdata_i[rx_ring_pkg::ST_INT_EN];
    end
    if (wr_config) begin
      nxt_loop = wdata_i[rx_ring_pkg::CF_LOOP];
      nxt_txcrc = wdata_i[rx_ring_pkg::CF_TXCRC];
    end
    if (wr_i && hit(addr_i, rx_ring_pkg::REG_BYTE_COUNT)) begin
      nxt_exp_len = wdata_i;
    end
    case (init_ff)
      INIT_IDLE: begin
        if (wr_config && wdata_i[rx_ring_pkg::CF_INIT]) begin
          nxt_init = INIT_RUN;
          nxt_init_cnt = 5'h00;
        end
      end
      INIT_RUN: begin
        nxt_init_cnt = 5'(init_cnt_ff + 5'h01);
        if (init_cnt_ff == 5'(rx_ring_pkg::INIT_CYCLES - 1)) begin
          nxt_init = INIT_DONE;
          nxt_init_flag = 1'b1;
        end
      end
      INIT_DONE: begin
        if (wr_config && wdata_i[rx_ring_pkg::CF_INIT]) begin
          nxt_init = INIT_RUN;
          nxt_init_cnt = 5'h00;
        end
      end
      default: nxt_init = INIT_IDLE;
    endcase
    if (miss_err_i) nxt_miss = 1'b1;
    if (babble_err_i) nxt_babble = 1'b1;
    if (host_return_i && owned_ff != '0) begin
      nxt_owned = (RING_AW+1)'(owned_ff - 1'b1);
    end
    if (mem_we) begin
      nxt_wr_ptr = RING_AW'(wr_ptr_ff + 1'b1);
      nxt_owned = (host_return_i && owned_ff != '0) ? owned_ff
                                                     : (RING_AW+1)'(owned_ff + 1'b1);
      nxt_last_status = desc_word;
      nxt_pkt_bytes = seg_last_i ? rx_ring_pkg::ZERO16 : 16'(pkt_bytes_ff + seg_bytes_i);
      nxt_in_pkt = !seg_last_i;
      nxt_rx_int = 1'b1;
      if (loop_ff && seg_last_i) begin
        nxt_loop_err = (16'(pkt_bytes_ff + seg_bytes_i) != expected)
                       || (seg_bytes_i > rx_ring_pkg::LOOP_MAX_BYTES) || in_pkt_ff;
      end
    end
  end

  always_comb begin
    nxt_rdata = rx_ring_pkg::ZERO16;
    case (addr_i)
      rx_ring_pkg::REG_STATUS: begin
        nxt_rdata[rx_ring_pkg::ST_ERR_SUM] = err_sum;
        nxt_rdata[rx_ring_pkg::ST_BABBLE] = babble_ff;
        nxt_rdata[rx_ring_pkg::ST_MISS] = miss_ff;
        nxt_rdata[rx_ring_pkg::ST_RX_INT] = rx_int_ff;
        nxt_rdata[rx_ring_pkg::ST_INIT_DONE] = init_flag_ff;
        nxt_rdata[rx_ring_pkg::ST_INT_EN] = int_en_ff;
      end
      rx_ring_pkg::REG_CONFIG: begin
        nxt_rdata[rx_ring_pkg::CF_LOOP] = loop_ff;
        nxt_rdata[rx_ring_pkg::CF_TXCRC] = txcrc_ff;
      end
      rx_ring_pkg::REG_DESC_STATUS: nxt_rdata = last_status_ff;
      rx_ring_pkg::REG_BYTE_COUNT: nxt_rdata = exp_len_ff;
      rx_ring_pkg::REG_OWNER: nxt_rdata = 16'(owned_ff);
      default: nxt_rdata = rx_ring_pkg::ZERO16;
    endcase
    // data stand only in the cycle after a read strobe
    if (!rd_i) begin
      nxt_rdata = rx_ring_pkg::ZERO16;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      init_ff <= INIT_IDLE;
      init_cnt_ff <= 5'h00;
      init_flag_ff <= 1'b0;
      rx_int_ff <= 1'b0;
      int_en_ff <= 1'b0;
      miss_ff <= 1'b0;
      babble_ff <= 1'b0;
      loop_ff <= 1'b0;
      txcrc_ff <= 1'b0;
      exp_len_ff <= 16'h0000;
      in_pkt_ff <= 1'b0;
      pkt_bytes_ff <= 16'h0000;
      wr_ptr_ff <= '0;
      owned_ff <= '0;
      loop_err_ff <= 1'b0;
      last_status_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
    end else begin
      init_ff <= nxt_init;
      init_cnt_ff <= nxt_init_cnt;
      init_flag_ff <= nxt_init_flag;
      rx_int_ff <= nxt_rx_int;
      int_en_ff <= nxt_int_en;
      miss_ff <= nxt_miss;
      babble_ff <= nxt_babble;
      loop_ff <= nxt_loop;
      txcrc_ff <= nxt_txcrc;
      exp_len_ff <= nxt_exp_len;
      in_pkt_ff <= nxt_in_pkt;
      pkt_bytes_ff <= nxt_pkt_bytes;
      wr_ptr_ff <= nxt_wr_ptr;
      owned_ff <= nxt_owned;
      loop_err_ff <= nxt_loop_err;
      last_status_ff <= nxt_last_status;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign loop_len_err_o = loop_err_ff;
  // level or of conditions, gated by enable
  assign int_o = int_en_ff & (rx_int_ff | init_flag_ff | err_sum);
endmodule

//--- test/rx_ring_service_props.sv
// Purpose: port checks for rx_ring_service
// Assumes: one clock, sync reset
// Notes: bound to every instance
`timescale 1ns/1ps
module rx_ring_service_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic seg_valid_i,
  input wire logic seg_last_i,
  input wire logic seg_ready_o,
  input wire logic int_o
);
  logic tk, rs, rdd, mid_ff;
  assign tk = seg_valid_i && seg_ready_o;
  assign rs = rd_i && !wr_i && addr_i == rx_ring_pkg::REG_STATUS;
  assign rdd = rd_i && addr_i == rx_ring_pkg::REG_DESC_STATUS;
  // inside a chained frame
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mid_ff <= 1'h0;
    end else if (tk) begin
      mid_ff <= !seg_last_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rx; (tk && !wr_i) ##1 rs |=> rdata_o[rx_ring_pkg::ST_RX_INT]; endproperty
  property p_off; wr_i && addr_i == 4'h0 && !wdata_i[rx_ring_pkg::ST_INT_EN] |=> !int_o;
  endproperty
  property p_or; rs ##1 rdata_o[6] && |{rdata_o[15], rdata_o[10], rdata_o[8]} |-> int_o;
  endproperty
  property p_gate; rs ##1 !rdata_o[6] |-> !int_o; endproperty
  property p_sum; rs |=> rdata_o[15] == (rdata_o[14] | rdata_o[12]); endproperty
  property p_ds; rdd |=> rdata_o[14] == |rdata_o[13:10]; endproperty
  property p_clr; wr_i && addr_i == 4'h0 && wdata_i[10] && !seg_valid_i ##1 !seg_valid_i
    ##1 rs |=> !rdata_o[10]; endproperty
  property p_sop; (tk && !mid_ff) ##1 rdd |=> rdata_o[rx_ring_pkg::DS_SOP]; endproperty
  property p_eop; tk ##1 rdd |=> rdata_o[rx_ring_pkg::DS_EOP] == $past(seg_last_i, 2);
  endproperty
  a_rx: assert property (p_rx) else $error("rx flag missing");
  a_off: assert property (p_off) else $error("int stays after disable");
  a_or: assert property (p_or) else $error("int low with cause");
  a_gate: assert property (p_gate) else $error("int high while disabled");
  a_sum: assert property (p_sum) else $error("status summary wrong");
  a_ds: assert property (p_ds) else $error("descriptor summary wrong");
  a_clr: assert property (p_clr) else $error("flag not cleared");
  a_sop: assert property (p_sop) else $error("first buffer lacks start");
  a_eop: assert property (p_eop) else $error("end mark wrong");
  c_last: cover property (tk && seg_last_i);
  c_chain: cover property (tk && !seg_last_i);
  c_int: cover property ($rose(int_o));
endmodule
bind rx_ring_service rx_ring_service_props chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .seg_valid_i(seg_valid_i), .seg_last_i(seg_last_i), .seg_ready_o(seg_ready_o),
  .int_o(int_o));

//--- test/rx_seg_source.sv
// Purpose: receive engine model handing filled buffers
// Assumes: go pulse per buffer
// Notes: fields scrambled between hand-offs
`timescale 1ns/1ps
module rx_seg_source (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [15:0] bytes_i,
  input wire logic last_i,
  input wire logic [2:0] err_i,
  input wire logic ready_i,
  output logic seg_valid_o,
  output logic [15:0] seg_bytes_o,
  output logic seg_last_o,
  output logic [2:0] seg_err_o
);
  always_ff @(posedge clk_i) begin
    seg_valid_o <= go_i && ready_i;
    if (go_i) begin
      seg_bytes_o <= bytes_i;
      seg_last_o <= last_i;
      seg_err_o <= err_i;
    end else begin
      seg_bytes_o <= ~seg_bytes_o;
      seg_last_o <= ~seg_last_o;
      seg_err_o <= ~seg_err_o;
    end
  end
endmodule

//--- test/tb_rx_ring_service.sv
// Purpose: register-level tests of rx_ring_service
// Assumes: default ring size
// Notes: ring filled once at the end to see ready drop
`timescale 1ns/1ps
module tb_rx_ring_service;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic wr_i = 1'h0, rd_i = 1'h0, go = 1'h0, last = 1'h0, host_return_i = 1'h0;
  logic miss_err_i = 1'h0, babble_err_i = 1'h0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, bytes = 16'h0000, rdata_o, seg_bytes_i;
  logic [2:0] errs = 3'h0, seg_err;
  logic seg_valid_i, seg_last_i, seg_ready_o, loop_len_err_o, int_o;
  logic [15:0] dx [0:2] = '{16'h6300, 16'h4B00, 16'h5300};
  logic [15:0] sx [0:1] = '{16'h9000, 16'hC000};
  int fails = 0, checked = 0;
  always #50 clk_i = ~clk_i;
  rx_seg_source src (.clk_i(clk_i), .go_i(go), .bytes_i(bytes), .last_i(last), .err_i(errs),
    .ready_i(seg_ready_o), .seg_valid_o(seg_valid_i), .seg_bytes_o(seg_bytes_i),
    .seg_last_o(seg_last_i), .seg_err_o(seg_err));
  rx_ring_service dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .seg_valid_i(seg_valid_i), .seg_bytes_i(seg_bytes_i), .seg_last_i(seg_last_i),
    .seg_fram_err_i(seg_err[0]), .seg_crc_err_i(seg_err[1]), .seg_oflo_err_i(seg_err[2]),
    .miss_err_i(miss_err_i), .babble_err_i(babble_err_i), .host_return_i(host_return_i),
    .seg_ready_o(seg_ready_o), .loop_len_err_o(loop_len_err_o), .int_o(int_o));
  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // read data plus {int, loop error}
  task automatic rd(input logic [3:0] a, input logic [15:0] d, input logic [1:0] f);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1;
    chk(rdata_o, d);
    chk({14'h0000, int_o, loop_len_err_o}, {14'h0000, f});
    @(posedge clk_i);
  endtask
  task automatic send(input logic [15:0] b, input logic l, input logic [2:0] e);
    go <= 1'h1;
    bytes <= b;
    last <= l;
    errs <= e;
    @(posedge clk_i);
    go <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic ret();
    host_return_i <= 1'h1;
    @(posedge clk_i);
    host_return_i <= 1'h0;
    @(posedge clk_i);
  endtask
  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    rd(4'h0, 16'h0000, 2'h0);
    rd(4'h5, 16'h0000, 2'h0);
    wr(4'h1, 16'h0004);
    repeat (20) @(posedge clk_i);
    rd(4'h0, 16'h0100, 2'h0);
    wr(4'h0, 16'h0140);
    rd(4'h0, 16'h0040, 2'h0);
    send(16'h000A, 1'h1, 3'h0);
    rd(4'h0, 16'h0440, 2'h2);
    rd(4'h2, 16'h0300, 2'h2);
    wr(4'h0, 16'h0400);
    rd(4'h0, 16'h0000, 2'h0);
    ret();
    send(16'h0040, 1'h0, 3'h0);
    rd(4'h2, 16'h0200, 2'h0);
    send(16'h0020, 1'h1, 3'h0);
    rd(4'h2, 16'h0100, 2'h0);
    ret();
    ret();
    for (int i = 0; i < 3; i++) begin
      send(16'h0008, 1'h1, 3'h1 << i);
      rd(4'h2, dx[i], 2'h0);
      ret();
    end
    wr(4'h0, 16'h5500);
    for (int i = 0; i < 2; i++) begin
      {babble_err_i, miss_err_i} <= 2'h1 << i;
      @(posedge clk_i);
      {babble_err_i, miss_err_i} <= 2'h0;
      @(posedge clk_i);
      rd(4'h0, sx[i], 2'h0);
      wr(4'h0, 16'h5000);
      rd(4'h0, 16'h0000, 2'h0);
    end
    wr(4'h1, 16'h0003);
    wr(4'h3, 16'h0014);
    send(16'h0010, 1'h1, 3'h0);
    rd(4'h3, 16'h0014, 2'h1);
    send(16'h0018, 1'h1, 3'h0);
    rd(4'h3, 16'h0014, 2'h0);
    wr(4'h3, 16'h0024);
    send(16'h0028, 1'h1, 3'h0);
    rd(4'h3, 16'h0024, 2'h1);
    send(16'h0010, 1'h0, 3'h0);
    rd(4'h2, 16'h4600, 2'h1);
    rd(4'h4, 16'h0004, 2'h1);
    repeat (4) send(16'h0010, 1'h0, 3'h0);
    rd(4'h4, 16'h0008, 2'h1);
    chk({15'h0000, seg_ready_o}, 16'h0000);
    send(16'h0010, 1'h1, 3'h0);
    rd(4'h4, 16'h0008, 2'h1);
    ret();
    chk({15'h0000, seg_ready_o}, 16'h0001);
    rd(4'h4, 16'h0007, 2'h1);
    tally_and_finish();
  end
endmodule
